// ---- rtl/stm_framer.sv ----
/*
 * s/t layer-1 multiframe and data path: s/q multiframe sync, q and s bit
 * insertion, multiframe events and gating of b1/b2/d/e between line
 * frame and terminal bus frame.
 * assumes line_frame_strobe and bus_frame_strobe are one-cycle pulses of
 * clk from the recovered timing; the line coder maps bits to pulses.
 */
//Contract
// - te, locked: host q bit goes into upstream fa every fifth frame.
// - te, not locked: each received fa bit is mirrored into next fa.
// - lock declared only after two correct complete multiframes.
// - lock dropped after errors in two consecutive multiframes.
// - lock state readable as a flag in s/q receive register one.
// - multiframe enable bit in s/q transmit register one switches sync.
// - nt mode generates multiframe structure only while enable is set.
// - nt mode inserts host s data into downstream s bit every fifth frame.
// - per-multiframe event and received s/q change event for the host.
// - te: line to bus transparent when activated or forced, else ones.
// - te: towards line also needs activation request or cleared disable.
// - stop/go on: d towards line depends on priority and echo.
// - trunk mode tolerates any phase between line and bus frames.
// - subscriber/nt: b1, b2, d transparent when activated or forced.
// - intelligent nt honours d-channel blocking from the bus handler.
// - level detect keeps reporting line signal while a loop is closed.
// - q bits in frames 1, 6, 11, 16; upstream fa zero elsewhere.
// - downstream m bit one marks first frame of a multiframe.
// - only s subchannel one is accessible to the host.
module stm_framer
	import stm_pkg::*;
(
	input wire logic clk, // 40 mhz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [2:0] mode_sel, // operating mode, stm_mode_t
	input wire logic [2:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic activated_state, // layer-1 state machine activated
	input wire logic act_req, // activation request command active
	input wire logic sg_stop, // stop/go result from echo/priority logic
	input wire logic d_block, // d access blocked by bus d handler
	input wire logic line_level_pin, // analogue level detector pin
	output logic level_detect, // line signal present
	input wire logic line_frame_strobe, // line frame boundary pulse
	input wire logic rx_fa_bit, // received fa bit
	input wire logic rx_n_bit, // received n bit
	input wire logic rx_m_bit, // received m bit
	input wire logic rx_s_bit, // received s bit
	input wire logic [7:0] rx_b1, // received b1 octet
	input wire logic [7:0] rx_b2, // received b2 octet
	input wire logic [1:0] rx_d, // received d bits
	input wire logic [1:0] rx_e, // received echo bits
	output logic tx_fa_bit, // fa bit to transmit
	output logic tx_m_bit, // m bit to transmit
	output logic tx_s_bit, // s bit to transmit
	output logic [7:0] tx_b1, // b1 octet to transmit
	output logic [7:0] tx_b2, // b2 octet to transmit
	output logic [1:0] tx_d, // d bits to transmit
	input wire logic bus_frame_strobe, // terminal bus frame pulse
	input wire logic [7:0] bus_b1_in, // b1 from terminal bus
	input wire logic [7:0] bus_b2_in, // b2 from terminal bus
	input wire logic [1:0] bus_d_in, // d from terminal bus
	output logic [7:0] bus_b1_out, // b1 to terminal bus
	output logic [7:0] bus_b2_out, // b2 to terminal bus
	output logic [1:0] bus_d_out, // d to terminal bus
	output logic [1:0] bus_e_out, // e to terminal bus
	output logic multiframe_tick_irq, // one pulse per multiframe
	output logic sq_change_irq // pulse when s/q nibble changed
);

	typedef struct packed {
		logic [7:0] sq_tx; // sq_transmit_reg_one
		logic [7:0] cmd; // transceiver_command_reg
		logic [2:0] dim; // d_access_mode_field
		logic [3:0] rx_nib; // last complete s/q nibble
		logic [3:0] cap_nib; // nibble being collected
		logic [4:0] idx; // frame index 0..19
		stm_sync_t sync;
		logic [1:0] good_cnt;
		logic [1:0] bad_cnt;
		logic mf_err; // error seen in current multiframe
		logic prev_fa; // last received fa; mirroring takes rx_fa_bit directly
		logic [7:0] rdata;
		logic tx_fa, tx_m, tx_s;
		logic [7:0] tx_b1, tx_b2;
		logic [1:0] tx_d;
		logic [7:0] hold_b1, hold_b2; // line data awaiting the bus
		logic [1:0] hold_d, hold_e;
		logic [7:0] up_b1, up_b2; // bus data awaiting the line
		logic [1:0] up_d;
		logic [7:0] bus_b1, bus_b2;
		logic [1:0] bus_d, bus_e;
		logic tick, change;
	} stm_state_t;

	stm_state_t st_q, st_d;
	logic lvl_sync;
	logic te_side, multiframe_enable, locked, slot_hit, first_frame, frame_err, mf_end;
	logic line_ok, tx_ok;
	logic [1:0] slot_no;

	// ------------------------------------------------------------------
	// level detector pin, no gating by loops
	// ------------------------------------------------------------------
	stm_sync2 #(.W(1)) u_lvl_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in(line_level_pin),
		.sync_out(lvl_sync)
	);
	assign level_detect = lvl_sync;

	// ------------------------------------------------------------------
	// decoded modes and slot position within the multiframe
	// ------------------------------------------------------------------
	assign te_side = (mode_sel == STM_MODE_TE) || (mode_sel == STM_MODE_TRUNK);
	assign multiframe_enable = st_q.sq_tx[MULTIFRAME_ENABLE_BIT];
	assign locked = (st_q.sync == STM_SYNC_LOCKED);
	assign first_frame = (st_q.idx == 5'h00);
	// q and s1 slots sit in frames 1, 6, 11 and 16; q1 is nibble bit 3
	always_comb begin
		slot_hit = 1'b1;
		slot_no = 2'h3;
		case (st_q.idx)
			5'h00: slot_no = 2'h3;
			MF_SLOT_TWO: slot_no = 2'h2;
			MF_SLOT_THREE: slot_no = 2'h1;
			MF_SLOT_FOUR: slot_no = 2'h0;
			default: slot_hit = 1'b0;
		endcase
	end
	// fa/n pair, fa pattern and m bit against the expected multiframe
	assign frame_err = (rx_n_bit == rx_fa_bit) || (rx_fa_bit != slot_hit) ||
		(rx_m_bit != first_frame);
	assign mf_end = line_frame_strobe && (st_q.idx == MF_LAST_FRAME) && (te_side ? locked : multiframe_enable);

	// transparency conditions; the bus side is loaded on its own strobe
	// so the two frame phases need no fixed relation
	assign line_ok = activated_state ||
		(st_q.cmd[SMDIS_BIT] && (st_q.cmd[TRANSMIT_INFO_SELECT_LSB +: 3] == TRANSMIT_INFO_SELECT_TRANSPARENT));
	assign tx_ok = te_side ? ((activated_state && act_req) ||
		(st_q.cmd[SMDIS_BIT] && !st_q.cmd[TRANSMIT_DATA_DISABLE_BIT])) : line_ok;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		st_d.change = 1'b0;
		st_d.rdata = 8'h00;

		// register port: reads answer in the next cycle, unmapped read zero
		if (reg_wr) begin
			case (reg_addr)
				ADDR_SQ_TX_ONE: st_d.sq_tx = reg_wdata;
				ADDR_TRANSCEIVER_COMMAND_REG: st_d.cmd = reg_wdata;
				ADDR_TR_MODE_TWO: st_d.dim = reg_wdata[2:0];
				default: st_d.sq_tx = st_q.sq_tx;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_SQ_TX_ONE: st_d.rdata = st_q.sq_tx;
				ADDR_SQ_RX_ONE: st_d.rdata = {3'h0, locked, st_q.rx_nib};
				ADDR_TRANSCEIVER_COMMAND_REG: st_d.rdata = st_q.cmd;
				ADDR_TR_MODE_TWO: st_d.rdata = {5'h00, st_q.dim};
				default: st_d.rdata = 8'h00;
			endcase
		end

		if (line_frame_strobe) begin
			st_d.prev_fa = rx_fa_bit;
			// frame counter modulo twenty
			st_d.idx = (st_q.idx == MF_LAST_FRAME) ? 5'h00 : st_q.idx + 5'h01;
			// s1 (te) or q (nt) bit of this slot; other s subchannels dropped
			if (slot_hit) begin
				st_d.cap_nib[slot_no] = te_side ? rx_s_bit : rx_fa_bit;
			end
			if (te_side) begin
				case (st_q.sync)
					STM_SYNC_HUNT: begin
						// m bit one with fa one starts a new multiframe
						if (rx_m_bit && rx_fa_bit && !rx_n_bit) begin
							st_d.idx = 5'h01;
							st_d.sync = STM_SYNC_CHECK;
						end else begin
							st_d.idx = 5'h00;
						end
						st_d.good_cnt = 2'h0;
						st_d.mf_err = 1'b0;
					end
					STM_SYNC_CHECK: begin
						st_d.mf_err = st_q.mf_err || frame_err;
						if (st_q.idx == MF_LAST_FRAME) begin
							st_d.mf_err = 1'b0;
							if (st_q.mf_err || frame_err) begin
								st_d.sync = STM_SYNC_HUNT;
							end else if (st_q.good_cnt + 2'h1 == SYNC_GOOD_NEED) begin
								st_d.sync = STM_SYNC_LOCKED;
								st_d.bad_cnt = 2'h0;
							end else begin
								st_d.good_cnt = st_q.good_cnt + 2'h1;
							end
						end
					end
					STM_SYNC_LOCKED: begin
						st_d.mf_err = st_q.mf_err || frame_err;
						if (st_q.idx == MF_LAST_FRAME) begin
							st_d.mf_err = 1'b0;
							if (!(st_q.mf_err || frame_err)) begin
								st_d.bad_cnt = 2'h0;
							end else if (st_q.bad_cnt + 2'h1 == SYNC_BAD_LIMIT) begin
								st_d.sync = STM_SYNC_HUNT;
							end else begin
								st_d.bad_cnt = st_q.bad_cnt + 2'h1;
							end
						end
					end
					default: st_d.sync = STM_SYNC_HUNT;
				endcase
				// upstream fa: q bit when locked, mirror otherwise
				if (locked && multiframe_enable) begin
					st_d.tx_fa = slot_hit ? st_q.sq_tx[slot_no] : 1'b0;
				end else begin
					st_d.tx_fa = rx_fa_bit;
				end
				st_d.tx_m = 1'b0;
				st_d.tx_s = 1'b0;
			end else begin
				// nt side: own multiframe only while enabled
				if (!multiframe_enable) begin
					st_d.idx = 5'h00;
				end
				st_d.tx_fa = multiframe_enable && slot_hit;
				st_d.tx_m = multiframe_enable && first_frame;
				st_d.tx_s = multiframe_enable && slot_hit && st_q.sq_tx[slot_no];
				st_d.sync = STM_SYNC_HUNT;
			end
			// bus to line data, d gated by stop/go or blocking
			st_d.tx_b1 = tx_ok ? st_q.up_b1 : 8'hff;
			st_d.tx_b2 = tx_ok ? st_q.up_b2 : 8'hff;
			st_d.tx_d = tx_ok ? st_q.up_d : 2'h3;
			if (te_side && st_q.dim[DIM_SG_BIT] && sg_stop) begin
				st_d.tx_d = 2'h3;
			end
			if ((mode_sel == STM_MODE_INT_NT) && d_block) begin
				st_d.tx_d = 2'h3;
			end
			// line data waits here for the next bus frame
			st_d.hold_e = rx_e;
		end

		// multiframe end: publish nibble and raise events
		if (mf_end) begin
			st_d.rx_nib = st_d.cap_nib;
			st_d.tick = 1'b1;
			st_d.change = (st_d.cap_nib != st_q.rx_nib);
		end

		// disabling multiframing forces the hunt state
		if (!multiframe_enable) begin
			st_d.sync = STM_SYNC_HUNT;
			st_d.tick = 1'b0;
			st_d.change = 1'b0;
		end

		if (line_frame_strobe) begin
			st_d.hold_b1 = rx_b1;
			st_d.hold_b2 = rx_b2;
			st_d.hold_d = rx_d;
		end
		if (bus_frame_strobe) begin
			// bus frame loads from held line data at any phase
			st_d.bus_b1 = line_ok ? st_q.hold_b1 : 8'hff;
			st_d.bus_b2 = line_ok ? st_q.hold_b2 : 8'hff;
			st_d.bus_d = line_ok ? st_q.hold_d : 2'h3;
			st_d.bus_e = (line_ok && te_side) ? st_q.hold_e : 2'h3;
			// bus data captured for the next line frame
			st_d.up_b1 = bus_b1_in;
			st_d.up_b2 = bus_b2_in;
			st_d.up_d = bus_d_in;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.sq_tx <= SQ_TX_RESET;
			st_q.cmd <= TRANSCEIVER_COMMAND_REG_RESET;
			st_q.dim <= DIM_RESET;
			st_q.rx_nib <= NIBBLE_RESET;
			st_q.sync <= STM_SYNC_HUNT;
			st_q.tx_b1 <= 8'hff;
			st_q.tx_b2 <= 8'hff;
			st_q.tx_d <= 2'h3;
			st_q.bus_b1 <= 8'hff;
			st_q.bus_b2 <= 8'hff;
			st_q.bus_d <= 2'h3;
			st_q.bus_e <= 2'h3;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs, all from flip-flops
	// ------------------------------------------------------------------
	assign reg_rdata = st_q.rdata;
	assign tx_fa_bit = st_q.tx_fa;
	assign tx_m_bit = st_q.tx_m;
	assign tx_s_bit = st_q.tx_s;
	assign tx_b1 = st_q.tx_b1;
	assign tx_b2 = st_q.tx_b2;
	assign tx_d = st_q.tx_d;
	assign bus_b1_out = st_q.bus_b1;
	assign bus_b2_out = st_q.bus_b2;
	assign bus_d_out = st_q.bus_d;
	assign bus_e_out = st_q.bus_e;
	assign multiframe_tick_irq = st_q.tick;
	assign sq_change_irq = st_q.change;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_unlocked_te_frame;
		line_frame_strobe && te_side && !(locked && multiframe_enable);
	endsequence
	sequence s_locked_gap_frame;
		line_frame_strobe && te_side && locked && multiframe_enable && !slot_hit;
	endsequence

	a_lock_after_two: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(locked) |-> $past(st_q.sync) == STM_SYNC_CHECK && $past(st_q.good_cnt) == 2'h1)
		else $error("lock without two good multiframes");
	a_unlock_two_bad: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(locked) && $past(multiframe_enable) && $past(te_side) |-> $past(st_q.bad_cnt) == 2'h1 && $past(mf_end))
		else $error("lock dropped without two bad multiframes");
	a_lock_flag_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == ADDR_SQ_RX_ONE |=> reg_rdata[LOCK_BIT] == $past(locked))
		else $error("lock flag read mismatch");
	a_multiframe_enable_off_hunt: assert property (@(posedge clk) disable iff (!rst_b)
		!multiframe_enable |=> !locked)
		else $error("lock held with multiframing off");
	a_fa_mirror: assert property (@(posedge clk) disable iff (!rst_b)
		s_unlocked_te_frame |=> tx_fa_bit == $past(rx_fa_bit))
		else $error("fa bit not mirrored");
	a_q_gap_zero: assert property (@(posedge clk) disable iff (!rst_b)
		s_locked_gap_frame |=> !tx_fa_bit)
		else $error("upstream fa not zero outside q slot");
	a_nt_idle: assert property (@(posedge clk) disable iff (!rst_b)
		line_frame_strobe && !te_side && !multiframe_enable |=> !tx_m_bit && !tx_fa_bit && !tx_s_bit)
		else $error("nt multiframe without enable");
	a_bus_ones: assert property (@(posedge clk) disable iff (!rst_b)
		bus_frame_strobe && !line_ok |=> bus_b1_out == 8'hff && bus_d_out == 2'h3)
		else $error("bus data not all ones");
	a_tick_single: assert property (@(posedge clk) disable iff (!rst_b)
		multiframe_tick_irq |=> !multiframe_tick_irq [*2])
		else $error("multiframe event not a single pulse");
	a_level_pass: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b, 2) && $past(line_level_pin, 3) && $past(line_level_pin, 2) |-> level_detect)
		else $error("level detect lost");
endmodule

// ---- rtl/stm_pkg.sv ----
/*
 * shared constants and types of the s/t multiframe and data path block:
 * register map, field positions, reset values, modes and sync states.
 * assumes a single 40 mhz clock domain and line frame strobes from the
 * recovered line timing.
 */
package stm_pkg;

	// ------------------------------------------------------------------
	// register map (plain register port, 3-bit address)
	// ------------------------------------------------------------------
	localparam logic [2:0] ADDR_SQ_TX_ONE = 3'h0; // sq_transmit_reg_one
	localparam logic [2:0] ADDR_SQ_RX_ONE = 3'h1; // sq_receive_reg_one
	localparam logic [2:0] ADDR_TRANSCEIVER_COMMAND_REG = 3'h2; // transceiver_command_reg
	localparam logic [2:0] ADDR_TR_MODE_TWO = 3'h3; // transceiver_mode_reg_two

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int MULTIFRAME_ENABLE_BIT = 7; // multiframe_enable in sq_transmit_reg_one
	localparam int LOCK_BIT = 4; // multiframe_locked_flag in sq_receive_reg_one
	localparam int TRANSMIT_INFO_SELECT_LSB = 0; // transmit_info_select, 3 bits
	localparam int TRANSMIT_DATA_DISABLE_BIT = 3; // transmit_data_disable
	localparam int SMDIS_BIT = 4; // layer-1 state machine disable
	localparam int DIM_SG_BIT = 0; // stop/go evaluation in d_access_mode_field

	// ------------------------------------------------------------------
	// values and reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] TRANSMIT_INFO_SELECT_TRANSPARENT = 3'h3;
	localparam logic [7:0] SQ_TX_RESET = 8'h00;
	localparam logic [7:0] TRANSCEIVER_COMMAND_REG_RESET = 8'h08;
	localparam logic [2:0] DIM_RESET = 3'h0;
	localparam logic [3:0] NIBBLE_RESET = 4'h0;

	// ------------------------------------------------------------------
	// multiframe timing
	// ------------------------------------------------------------------
	localparam logic [4:0] MF_LAST_FRAME = 5'h13; // frame 20 of 20, index 19
	localparam logic [4:0] MF_SLOT_TWO = 5'h05; // frame 6
	localparam logic [4:0] MF_SLOT_THREE = 5'h0a; // frame 11
	localparam logic [4:0] MF_SLOT_FOUR = 5'h0f; // frame 16
	localparam logic [1:0] SYNC_GOOD_NEED = 2'h2; // good multiframes to lock
	localparam logic [1:0] SYNC_BAD_LIMIT = 2'h2; // bad multiframes to unlock

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		STM_MODE_TE = 3'b000,
		STM_MODE_TRUNK = 3'b001, // trunk_line_mode
		STM_MODE_SUBSCR = 3'b010, // subscriber_line_mode
		STM_MODE_NT = 3'b011,
		STM_MODE_INT_NT = 3'b100
	} stm_mode_t;

	typedef enum logic [1:0] {
		STM_SYNC_HUNT = 2'b00,
		STM_SYNC_CHECK = 2'b01,
		STM_SYNC_LOCKED = 2'b10
	} stm_sync_t;

endpackage

// ---- rtl/stm_sync2.sv ----
/*
 * two flip-flop synchroniser for levels arriving from outside the clock
 * domain. assumes the input is a slow level, not a pulse.
 */
module stm_sync2
	import stm_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [W-1:0] async_in, // level from a pin
	output logic [W-1:0] sync_out // synchronised level
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} stm_sync2_state_t;

	stm_sync2_state_t st_q, st_d;

	// ------------------------------------------------------------------
	// next state: first stage feeds only the second
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;
endmodule

// ---- testbench/stm_far_end.sv ----
/*
 * far-end line model: sends framed content, one frame every 8 clocks,
 * in twenty-frame multiframes; can spoil frame 2 on request.
 * assumes the bench owns clk, rst_b and the random seed.
 */
module stm_far_end
	import stm_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic bad, // spoil fa of frame 2
	output logic lfs, // line frame strobe
	output logic [4:0] idx, // index of the frame on offer
	output logic fa, // fa bit
	output logic n, // n bit
	output logic m, // m bit
	output logic s, // s bit
	output logic [7:0] b1, // b1 octet
	output logic [1:0] d, // d bits
	output logic [1:0] e // echo bits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	logic [4:0] nx;
	logic fv;
	// ----------------------------------------------------------------
	// frame generator; between frames the lines flip, nothing holds them
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
			idx <= MF_LAST_FRAME;
			lfs <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			lfs <= (cnt_q == 3'h7);
			nx = (idx == MF_LAST_FRAME) ? 5'h00 : idx + 5'h01;
			fv = (nx % 5 == 0) ^ (bad && nx == 5'h01);
			if (cnt_q == 3'h7) begin
				idx <= nx;
				fa <= fv;
				n <= ~fv;
				m <= (nx == 5'h00);
				{s, b1, d, e} <= 13'($urandom);
			end else
				{fa, n, m, s, b1, d, e} <= ~{fa, n, m, s, b1, d, e};
		end
	end
endmodule

// ---- testbench/stm_framer_test.sv ----
/*
 * self-checking bench of the s/t multiframe and data path block.
 * assumes the far-end model offers a frame every 8 clocks; the terminal
 * bus frame follows each line frame by 3 clocks.
 */
module stm_framer_test
	import stm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, reg_wr, reg_rd, activated_state, act_req, sg_stop, d_block, line_level_pin, bad;
	logic lfs, rx_fa, rx_n, rx_m, rx_s, tx_fa, tx_m, tx_s, level_detect, tick, chg, rd_d, efa, df;
	logic [2:0] mode_sel, reg_addr;
	logic [2:0] bdl = 3'h0; // bus strobe delay line
	logic [4:0] fidx;
	logic [7:0] reg_wdata, reg_rdata, tx_b1, bus_b1_out, rx_b1, hb1, pb1, tb2, bb2, ub1;
	logic [1:0] tx_d, bus_e_out, rx_d, rx_e, hd, pd, he, bd, ud;
	logic [3:0] q, snib, lsnib;
	logic [7:0] exp_q[$], msk_q[$];
	int n_mismatch, n_checks, n_tick, n_chg, n_xchg, k, fam, dm, bm, nt;

	stm_far_end far (.clk(clk), .rst_b(rst_b), .bad(bad), .lfs(lfs), .idx(fidx), .fa(rx_fa), .n(rx_n),
		.m(rx_m), .s(rx_s), .b1(rx_b1), .d(rx_d), .e(rx_e));
	stm_framer DUT (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .activated_state(activated_state),
		.act_req(act_req), .sg_stop(sg_stop), .d_block(d_block), .line_level_pin(line_level_pin),
		.level_detect(level_detect), .line_frame_strobe(lfs), .rx_fa_bit(rx_fa), .rx_n_bit(rx_n),
		.rx_m_bit(rx_m), .rx_s_bit(rx_s), .rx_b1(rx_b1), .rx_b2(~rx_b1), .rx_d(rx_d), .rx_e(rx_e),
		.tx_fa_bit(tx_fa), .tx_m_bit(tx_m), .tx_s_bit(tx_s), .tx_b1(tx_b1), .tx_b2(tb2), .tx_d(tx_d),
		.bus_frame_strobe(bdl[2]), .bus_b1_in(ub1), .bus_b2_in(~ub1), .bus_d_in(ud),
		.bus_b1_out(bus_b1_out), .bus_b2_out(bb2), .bus_d_out(bd), .bus_e_out(bus_e_out),
		.multiframe_tick_irq(tick), .sq_change_irq(chg));

	// clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// read answers stand one cycle only, so they are taken in that cycle
	always @(posedge clk) begin
		rd_d <= reg_rd;
		bdl <= {bdl[1:0], lfs};
		if (tick === 1'b1) n_tick++;
		if (chg === 1'b1) n_chg++;
	end
	always @(negedge clk) if (rd_d === 1'b1) chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());

	// line side: work out what each frame must give, check once it lands
	initial forever begin
		@(posedge clk);
		if (lfs === 1'b1) begin
			efa = (fam == 1) ? rx_fa : (fidx % 5 == 0) && q[3 - fidx / 5];
			if (fidx % 5 == 0) snib[3 - fidx / 5] = rx_s;
			if (fidx == MF_LAST_FRAME) n_xchg += int'(snib != lsnib);
			if (fidx == MF_LAST_FRAME) lsnib = snib;
			// bus offers fresh data each line frame; the next line frame must carry it
			pb1 = ub1; pd = ud; hb1 = rx_b1; hd = rx_d; he = rx_e;
			ub1 <= 8'($urandom);
			ud <= 2'($urandom);
			@(negedge clk);
			if (fam != 0) chk(tx_fa, efa);
			if (dm != 0) chk(tx_b1, dm == 1 ? 8'hff : pb1);
			if (dm != 0) chk(tb2, dm == 1 ? 8'hff : ~pb1);
			if (dm != 0) chk(tx_d, (dm == 1 || df) ? 2'h3 : pd);
			if (nt == 1) chk({tx_fa, tx_m, tx_s}, 3'h0);
			if (nt == 2) k = (tx_m === 1'b1) ? 0 : (k == 99) ? 99 : k + 1;
			if (nt == 2 && k != 99) chk({k < 20, tx_fa, tx_s}, {1'b1, k % 5 == 0, k % 5 == 0 && q[3 - k / 5]});
		end
	end

	// terminal bus side, three clocks behind each line frame
	initial forever begin
		@(posedge clk);
		if (bdl[2] === 1'b1 && bm != 0) begin
			@(negedge clk);
			chk(bus_b1_out, bm == 1 ? 8'hff : hb1);
			chk(bb2, bm == 1 ? 8'hff : ~hb1);
			chk(bd, bm == 1 ? 2'h3 : hd);
			chk(bus_e_out, (bm == 1 || nt != 0) ? 2'h3 : he);
		end
	end

	// a hang is cut short well beyond the expected run of some 3000 clocks
	initial begin
		#500us;
		n_mismatch++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] msk);
		exp_q.push_back(v);
		msk_q.push_back(msk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wf(input int cnt);
		repeat (cnt) begin
			@(posedge clk);
			while (lfs !== 1'b1) @(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask

	// checks pause for two frames while the gating settles
	task automatic gate(input logic a, input logic r, input int d_m, input int b_m, input logic f);
		dm = 0;
		bm = 0;
		activated_state <= a;
		act_req <= r;
		wf(2);
		dm = d_m;
		bm = b_m;
		df = f;
	endtask

	task automatic rst(input logic [2:0] md);
		dm = 0;
		bm = 0;
		rst_b <= 1'b0;
		mode_sel <= md;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
	endtask

	initial begin
		int s0, s1, s2;
		void'($urandom(81));
		{reg_wr, reg_rd, activated_state, act_req, sg_stop, d_block, line_level_pin, bad} = 8'h00;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		df = 1'b0;
		lsnib = 4'h0;
		k = 99;
		q = 4'($urandom);
		rst(STM_MODE_TE);
		rd(ADDR_SQ_TX_ONE, SQ_TX_RESET, 8'hff);
		rd(ADDR_TRANSCEIVER_COMMAND_REG, TRANSCEIVER_COMMAND_REG_RESET, 8'hff);
		rd(ADDR_TR_MODE_TWO, {5'h00, DIM_RESET}, 8'hff);
		rd(3'h6, 8'h00, 8'hff);
		wr(ADDR_SQ_RX_ONE, 8'hff);
		rd(ADDR_SQ_RX_ONE, {4'h0, NIBBLE_RESET}, 8'hff);
		line_level_pin <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk(level_detect, 1'b1);
		@(posedge clk);
		gate(0, 0, 1, 1, 0);
		gate(1, 0, 1, 2, 0);
		gate(1, 1, 2, 2, 0);
		wr(ADDR_TR_MODE_TWO, 8'h01);
		sg_stop <= 1'b1;
		gate(1, 1, 2, 2, 1);
		sg_stop <= 1'b0;
		gate(1, 1, 2, 2, 0);
		wr(ADDR_TRANSCEIVER_COMMAND_REG, 8'h1b);
		gate(0, 0, 1, 2, 0);
		wr(ADDR_TRANSCEIVER_COMMAND_REG, 8'h12);
		gate(0, 0, 2, 1, 0);
		wr(ADDR_TRANSCEIVER_COMMAND_REG, 8'h13);
		gate(0, 0, 2, 2, 0);
		fam = 1;
		wf(25);
		rd(ADDR_SQ_RX_ONE, 8'h00, 8'h10);
		fam = 0;
		wr(ADDR_SQ_TX_ONE, {4'h8, q});
		wf(30);
		rd(ADDR_SQ_RX_ONE, 8'h00, 8'h10);
		wf(35);
		rd(ADDR_SQ_RX_ONE, 8'h10, 8'h10);
		fam = 2;
		wf(21);
		s0 = n_tick;
		s1 = n_chg;
		s2 = n_xchg;
		wf(40);
		chk(8'(n_tick - s0), 8'h02);
		chk(8'(n_chg - s1), 8'(n_xchg - s2));
		@(posedge clk iff tick === 1'b1);
		rd(ADDR_SQ_RX_ONE, {4'h1, lsnib}, 8'hff);
		bad <= 1'b1;
		wf(20);
		bad <= 1'b0;
		wf(20);
		rd(ADDR_SQ_RX_ONE, 8'h10, 8'h10);
		fam = 0;
		bad <= 1'b1;
		wf(60);
		bad <= 1'b0;
		rd(ADDR_SQ_RX_ONE, 8'h00, 8'h10);
		fam = 1;
		wf(10);
		fam = 0;
		rst(STM_MODE_TRUNK);
		gate(1, 1, 2, 2, 0);
		rst(STM_MODE_SUBSCR);
		nt = 3;
		gate(1, 0, 2, 2, 0);
		rst(STM_MODE_NT);
		nt = 1;
		wf(25);
		nt = 0;
		wr(ADDR_SQ_TX_ONE, {4'h8, q});
		nt = 2;
		gate(1, 0, 2, 2, 0);
		wf(45);
		chk(k != 99, 1'b1);
		nt = 3;
		rst(STM_MODE_INT_NT);
		d_block <= 1'b1;
		gate(1, 0, 2, 2, 1);
		wf(3);
		finish_test();
	end
endmodule
